/* File: hw/cpusb_top.sv */
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/100ps
// Processor sideband outputs with a classic Wishbone slave
module cpusb_top
	import cpusb_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [WB_AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [WB_DW-1:0] wb_dat_i,
	output logic [WB_DW-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic coproc_error_in_n_i,
	input wire logic kbc_reset_request_n_i,
	input wire logic pci_serr_n_i,
	input wire logic isa_channel_check_n_i,
	input wire logic shutdown_cycle_i,
	input wire logic ext_irq_pending_i,
	input wire logic power_on_suspend_i,
	input wire logic cpu_type_strap_i,
	output logic coproc_error_request_o,
	output logic cpu_irq_out_o,
	output logic ignore_numeric_exc_n_o,
	output logic ignore_numeric_exc_n_oe_o,
	output logic init_o,
	output logic nmi_o
);
	// Whole module state
	typedef struct packed {
		logic ack; // Bus answer
		logic [WB_DW-1:0] rdata; // Read data
		logic [7:0] fast_ctrl; // Fast-control port
		logic cp_en; // Error reporting enable
		logic sys_rst; // System-reset select
		logic cpu_rst; // Reset-CPU bit
		logic serr_dis; // System error source disable
		logic isa_channel_check_n_dis; // Channel check source disable
		logic serr_st; // System error latched
		logic isa_channel_check_n_st; // Channel check latched
		logic nmi_mask; // Global NMI mask
		logic strap; // Processor type, caught in reset
		logic kbc_prev; // Last synced keyboard request
		logic [INIT_CW-1:0] init_cnt; // Init clocks left
		logic init; // Init pin level
		logic ign; // Ignore pin enable
		logic coproc_error_request; // Coprocessor request
		logic cpu_irq_out; // Processor interrupt
		logic nmi; // NMI pin level
	} cpusb_state_t;

	cpusb_state_t st_ff;
	cpusb_state_t nxt_st;

	logic [3:0] sync_q; // Synchronised active-low inputs
	logic coproc_error_in_n_act; // Coprocessor error active
	logic kbc_act; // Keyboard reset request active
	logic serr_act; // System error active
	logic isa_channel_check_n_act; // Channel check active
	logic bus_req; // Request awaiting answer
	logic bus_wr; // Write taking effect this edge
	logic wr_lane0; // Write touches the low byte
	logic [WB_DW-1:0] rd_mux; // Read value of addressed word
	logic init_go; // Any init trigger
	logic nmi_pend; // Latched source present

	// Address match on the word, byte bits ignored
	function automatic logic hit(input logic [WB_AW-1:0] adr,
			input logic [WB_AW-1:0] target);
		hit = (adr[WB_AW-1:2] == target[WB_AW-1:2]);
	endfunction

	// Byte address of a printed index
	function automatic logic [WB_AW-1:0] idx_addr(input logic [9:0] idx);
		idx_addr = {idx, 2'b00};
	endfunction

	// Event inputs crossed in before use
	cpusb_sync #(
		.W(4),
		.IDLE(SYNC_IDLE)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({isa_channel_check_n_i, pci_serr_n_i,
			kbc_reset_request_n_i, coproc_error_in_n_i}),
		.q_o(sync_q)
	);

	// Active-high views of the synced inputs
	assign coproc_error_in_n_act = ~sync_q[0];
	assign kbc_act = ~sync_q[1];
	assign serr_act = ~sync_q[2];
	assign isa_channel_check_n_act = ~sync_q[3];

	// One wait state: answer the cycle after the request
	assign bus_req = wb_cyc_i & wb_stb_i;
	// Writes land on the edge where the master sees ack
	assign bus_wr = bus_req & wb_we_i & st_ff.ack;
	// All registers are eight bits in lane zero
	assign wr_lane0 = bus_wr & wb_sel_i[0];

	// Read multiplexer; unmapped words read zero
	always_comb begin
		rd_mux = '0;
		if (hit(wb_adr_i, idx_addr(FAST_CTRL_IDX))) begin
			rd_mux[7:0] = st_ff.fast_ctrl;
		end else if (hit(wb_adr_i, RST_CTRL_ADDR)) begin
			rd_mux[RC_CP_EN_BIT] = st_ff.cp_en;
			rd_mux[RC_SYS_RST_BIT] = st_ff.sys_rst;
			rd_mux[RC_CPU_RST_BIT] = st_ff.cpu_rst;
			rd_mux[RC_INIT_ST_BIT] = (st_ff.init_cnt != '0);
			rd_mux[RC_IGN_ST_BIT] = st_ff.ign;
			rd_mux[RC_COPROC_ERROR_IN_N_ST_BIT] = coproc_error_in_n_act;
		end else if (hit(wb_adr_i, NMI_SC_ADDR)) begin
			// Handler finds the source here
			rd_mux[NMI_SERR_DIS_BIT] = st_ff.serr_dis;
			rd_mux[NMI_ISA_CHANNEL_CHECK_N_DIS_BIT] = st_ff.isa_channel_check_n_dis;
			rd_mux[NMI_ISA_CHANNEL_CHECK_N_ST_BIT] = st_ff.isa_channel_check_n_st;
			rd_mux[NMI_SERR_ST_BIT] = st_ff.serr_st;
		end else if (hit(wb_adr_i, NMI_MASK_ADDR)) begin
			rd_mux[NMI_MASK_BIT] = st_ff.nmi_mask;
		end
		// Error-clear register is write-only, reads zero
	end

	// Init triggers, gathered into one pulse start
	always_comb begin
		init_go = 1'b0;
		// Soft reset through the reset control register
		if (wr_lane0 && hit(wb_adr_i, RST_CTRL_ADDR)) begin
			if (!wb_dat_i[RC_SYS_RST_BIT] && !st_ff.cpu_rst &&
					wb_dat_i[RC_CPU_RST_BIT]) begin
				init_go = 1'b1;
			end
		end
		// Write of a one to port bit zero
		if (wr_lane0 && hit(wb_adr_i, idx_addr(FAST_CTRL_IDX)) &&
				wb_dat_i[0]) begin
			init_go = 1'b1;
		end
		// Shutdown special cycle seen on the bus
		if (shutdown_cycle_i) begin
			init_go = 1'b1;
		end
		// Keyboard controller request, on its assertion
		if (kbc_act && !st_ff.kbc_prev) begin
			init_go = 1'b1;
		end
	end

	// Delivered only with both disables and the mask clear
	assign nmi_pend = (st_ff.serr_st | st_ff.isa_channel_check_n_st) & ~st_ff.serr_dis &
		~st_ff.isa_channel_check_n_dis & ~st_ff.nmi_mask;

	// Next-state logic
	always_comb begin
		nxt_st = st_ff;
		// Bus answer and read capture
		nxt_st.ack = bus_req & ~st_ff.ack;
		if (bus_req && !st_ff.ack) begin
			nxt_st.rdata = rd_mux;
		end
		nxt_st.kbc_prev = kbc_act;

		// Register writes
		if (wr_lane0) begin
			if (hit(wb_adr_i, idx_addr(FAST_CTRL_IDX))) begin
				nxt_st.fast_ctrl = wb_dat_i[7:0];
			end
			if (hit(wb_adr_i, RST_CTRL_ADDR)) begin
				nxt_st.cp_en = wb_dat_i[RC_CP_EN_BIT];
				nxt_st.sys_rst = wb_dat_i[RC_SYS_RST_BIT];
				nxt_st.cpu_rst = wb_dat_i[RC_CPU_RST_BIT];
			end
			if (hit(wb_adr_i, NMI_SC_ADDR)) begin
				nxt_st.serr_dis = wb_dat_i[NMI_SERR_DIS_BIT];
				nxt_st.isa_channel_check_n_dis = wb_dat_i[NMI_ISA_CHANNEL_CHECK_N_DIS_BIT];
			end
			if (hit(wb_adr_i, NMI_MASK_ADDR)) begin
				nxt_st.nmi_mask = wb_dat_i[NMI_MASK_BIT];
			end
		end

		// Init pulse counter; a new trigger restarts it
		if (init_go) begin
			nxt_st.init_cnt = INIT_CW'(INIT_CYCLES);
		end else if (st_ff.init_cnt != '0) begin
			nxt_st.init_cnt = st_ff.init_cnt - 1'b1;
		end
		// Suspend forces the idle level
		if (power_on_suspend_i) begin
			nxt_st.init = st_ff.strap;
		end else begin
			nxt_st.init = (nxt_st.init_cnt != '0) ^ st_ff.strap;
		end

		// Coprocessor error forwards request thirteen
		nxt_st.coproc_error_request = coproc_error_in_n_act;
		// Ignore: set by a write only while the error is active
		if (!coproc_error_in_n_act || !nxt_st.cp_en) begin
			nxt_st.ign = 1'b0;
		end else if (wr_lane0 && hit(wb_adr_i, idx_addr(CPERR_CLR_IDX))) begin
			nxt_st.ign = 1'b1;
		end
		// Released while suspended
		if (power_on_suspend_i) begin
			nxt_st.ign = 1'b0;
		end

		// Processor interrupt from any pending request
		nxt_st.cpu_irq_out = (coproc_error_in_n_act | ext_irq_pending_i) &
			~power_on_suspend_i;

		// Sources latch while enabled; a disable clears them
		if (nxt_st.serr_dis) begin
			nxt_st.serr_st = 1'b0;
		end else if (serr_act) begin
			nxt_st.serr_st = 1'b1;
		end
		if (nxt_st.isa_channel_check_n_dis) begin
			nxt_st.isa_channel_check_n_st = 1'b0;
		end else if (isa_channel_check_n_act) begin
			nxt_st.isa_channel_check_n_st = 1'b1;
		end
		// Level stays high while latched; the edge marks the event
		nxt_st.nmi = nmi_pend & ~power_on_suspend_i;

		// Synchronous reset; strap is sampled while held
		if (rst_i) begin
			nxt_st.ack = 1'b0;
			nxt_st.rdata = '0;
			nxt_st.fast_ctrl = FAST_CTRL_RST;
			nxt_st.cp_en = CP_EN_RST;
			nxt_st.sys_rst = 1'b0;
			nxt_st.cpu_rst = 1'b0;
			nxt_st.serr_dis = NMI_DIS_RST;
			nxt_st.isa_channel_check_n_dis = NMI_DIS_RST;
			nxt_st.serr_st = 1'b0;
			nxt_st.isa_channel_check_n_st = 1'b0;
			nxt_st.nmi_mask = NMI_MASK_RST;
			nxt_st.strap = cpu_type_strap_i;
			nxt_st.kbc_prev = 1'b0;
			nxt_st.init_cnt = '0;
			nxt_st.init = cpu_type_strap_i;
			nxt_st.ign = 1'b0;
			nxt_st.coproc_error_request = 1'b0;
			nxt_st.cpu_irq_out = 1'b0;
			nxt_st.nmi = 1'b0;
		end
	end

	// Register the whole state
	always_ff @(posedge clk_i) begin
		st_ff <= nxt_st;
	end

	// Outputs straight from flops, except the ignore data, a constant low
	assign wb_ack_o = st_ff.ack;
	assign wb_dat_o = st_ff.rdata;
	assign coproc_error_request_o = st_ff.coproc_error_request;
	assign cpu_irq_out_o = st_ff.cpu_irq_out;
	// Open drain: only ever pulls low
	assign ignore_numeric_exc_n_o = 1'b0;
	assign ignore_numeric_exc_n_oe_o = st_ff.ign;
	assign init_o = st_ff.init;
	assign nmi_o = st_ff.nmi;
endmodule

/* File: hw/cpusb_pkg.sv */
// Behaviour
// - Coprocessor error raises internal request thirteen
// - Error-register write with error active asserts ignore
// - Ignore holds until coprocessor error negates
// - Error-register write without error does nothing
// - Ignore drives only when error reporting enabled
// - Ignore pin released in reset and suspend
// - Reset-CPU rising, system-reset clear, starts init
// - Shutdown special cycle starts init pulse
// - Keyboard reset request starts init pulse
// - Fast-control port bit zero write starts init
// - Init pulse lasts sixty-four clocks
// - Init polarity follows processor-type strap
// - Processor interrupt follows any pending request
// - Processor interrupt low in reset, suspend
// - System error or channel check raises NMI
// - Setting source disable bit clears its NMI
// - NMI only when disables and mask zero
// - NMI low at reset and in suspend
package cpusb_pkg;
	localparam int WB_AW = 12; // Byte address width
	localparam int WB_DW = 32; // Data width
	// Printed register indices; byte address is four times these
	localparam logic [9:0] FAST_CTRL_IDX = 10'h092;
	localparam logic [9:0] CPERR_CLR_IDX = 10'h0f0;
	// Control registers with no printed offset
	localparam logic [11:0] RST_CTRL_ADDR = 12'h200;
	localparam logic [11:0] NMI_SC_ADDR = 12'h184;
	localparam logic [11:0] NMI_MASK_ADDR = 12'h1c0;
	// Reset control fields
	localparam int RC_CP_EN_BIT = 0;
	localparam int RC_SYS_RST_BIT = 1;
	localparam int RC_CPU_RST_BIT = 2;
	localparam int RC_INIT_ST_BIT = 4;
	localparam int RC_IGN_ST_BIT = 5;
	localparam int RC_COPROC_ERROR_IN_N_ST_BIT = 6;
	// NMI status and control fields
	localparam int NMI_SERR_DIS_BIT = 2;
	localparam int NMI_ISA_CHANNEL_CHECK_N_DIS_BIT = 3;
	localparam int NMI_ISA_CHANNEL_CHECK_N_ST_BIT = 6;
	localparam int NMI_SERR_ST_BIT = 7;
	localparam int NMI_MASK_BIT = 7;
	// Values after reset
	localparam logic [7:0] FAST_CTRL_RST = 8'h00;
	localparam logic CP_EN_RST = 1'b0;
	localparam logic NMI_DIS_RST = 1'b0;
	localparam logic NMI_MASK_RST = 1'b1;
	// Init pulse length in clocks
	localparam int INIT_CYCLES = 64;
	localparam int INIT_CW = 7;
	// Synchroniser idle value, all inputs active low
	localparam logic [3:0] SYNC_IDLE = 4'hf;
endpackage

/* File: hw/cpusb_sync.sv */
`timescale 1ns/100ps
// Two-stage synchroniser for a group of unrelated levels
module cpusb_sync #(
	parameter int W = 4,
	parameter logic [W-1:0] IDLE = '1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	// Both stages in one state word
	typedef struct packed {
		logic [W-1:0] meta; // First stage, read only by second
		logic [W-1:0] sync; // Second stage, safe to use
	} cpusb_sync_t;

	cpusb_sync_t st_ff;
	cpusb_sync_t nxt_st;

	// Shift the stages
	always_comb begin
		nxt_st = st_ff;
		nxt_st.meta = d_i;
		nxt_st.sync = st_ff.meta;
		if (rst_i) begin
			// Idle level avoids false events after reset
			nxt_st.meta = IDLE;
			nxt_st.sync = IDLE;
		end
	end

	// Register the state
	always_ff @(posedge clk_i) begin
		st_ff <= nxt_st;
	end

	assign q_o = st_ff.sync;
endmodule

/* File: dv/cpusb_asserts.sv */
`timescale 1ns/100ps
// Ties each sideband output to its cause
module cpusb_asserts
	import cpusb_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [WB_AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [WB_DW-1:0] wb_dat_i,
	input wire logic wb_ack_o,
	input wire logic coproc_error_in_n_i,
	input wire logic kbc_reset_request_n_i,
	input wire logic shutdown_cycle_i,
	input wire logic ext_irq_pending_i,
	input wire logic power_on_suspend_i,
	input wire logic cpu_type_strap_i,
	input wire logic coproc_error_request_o,
	input wire logic cpu_irq_out_o,
	input wire logic ignore_numeric_exc_n_oe_o,
	input wire logic init_o,
	input wire logic nmi_o
);
	logic strap_ff; // Strap as seen in reset
	logic mask_ff; // Shadow of the NMI mask
	logic [1:0] dis_ff; // Shadow of both NMI disables
	logic [7:0] cnt_ff; // Length of the running init pulse
	wire act = init_o ^ strap_ff;
	// Write lands at the ack edge, lane 0 only
	wire wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
	// Shadows follow landed writes; mask comes up set
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strap_ff <= cpu_type_strap_i;
			mask_ff <= 1'b1;
			dis_ff <= 2'b00;
		end else if (wr && wb_adr_i[11:2] == NMI_MASK_ADDR[11:2]) begin
			mask_ff <= wb_dat_i[NMI_MASK_BIT];
		end else if (wr && wb_adr_i[11:2] == NMI_SC_ADDR[11:2]) begin
			dis_ff <= wb_dat_i[3:2];
		end
		cnt_ff <= (rst_i || !act) ? 8'h00 : cnt_ff + 8'h01;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_err_held;
		!coproc_error_in_n_i [*4];
	endsequence
	sequence s_port_wr;
		wr && wb_adr_i[11:2] == FAST_CTRL_IDX && wb_dat_i[0];
	endsequence
	a_coproc_error_request_raise: assert property (s_err_held |-> ##[0:2] coproc_error_request_o)
		else $error("request 13 missing");
	a_ign_release: assert property (coproc_error_in_n_i [*5] |-> !ignore_numeric_exc_n_oe_o)
		else $error("ignore driven without error");
	a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !ignore_numeric_exc_n_oe_o
		&& !cpu_irq_out_o && !nmi_o && init_o == $past(cpu_type_strap_i))
		else $error("outputs active in reset");
	a_susp_quiet: assert property (power_on_suspend_i |=> !ignore_numeric_exc_n_oe_o
		&& !cpu_irq_out_o && !nmi_o && !act)
		else $error("outputs active in suspend");
	a_init_width: assert property ($fell(act) && !$past(power_on_suspend_i) |-> cnt_ff == 8'h40)
		else $error("init pulse length wrong");
	a_init_shutdown: assert property (shutdown_cycle_i && !power_on_suspend_i |=> act)
		else $error("no init on shutdown");
	a_init_port: assert property (s_port_wr |=> act)
		else $error("no init on port write");
	a_init_kbc: assert property ($fell(kbc_reset_request_n_i) |-> ##[2:4] act)
		else $error("no init on keyboard request");
	a_nmi_gated: assert property (nmi_o |-> $past(!mask_ff && dis_ff == 2'b00))
		else $error("nmi while masked");
	a_irq_pending: assert property (ext_irq_pending_i && !power_on_suspend_i |=> cpu_irq_out_o)
		else $error("interrupt not forwarded");
endmodule
bind cpusb_top cpusb_asserts u_cpusb_asserts (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .coproc_error_in_n_i(coproc_error_in_n_i),
	.kbc_reset_request_n_i(kbc_reset_request_n_i), .shutdown_cycle_i(shutdown_cycle_i),
	.ext_irq_pending_i(ext_irq_pending_i), .power_on_suspend_i(power_on_suspend_i),
	.cpu_type_strap_i(cpu_type_strap_i), .coproc_error_request_o(coproc_error_request_o),
	.cpu_irq_out_o(cpu_irq_out_o), .ignore_numeric_exc_n_oe_o(ignore_numeric_exc_n_oe_o),
	.init_o(init_o), .nmi_o(nmi_o));

/* File: dv/cpusb_host_model.sv */
`timescale 1ns/100ps
// Processor end: counts init pulses and NMI edges
module cpusb_host_model (
	input wire logic clk_i,
	input wire logic strap_i,
	input wire logic init_i,
	input wire logic nmi_i,
	input wire logic ign_n_i,
	input wire logic ign_oe_i,
	output logic ign_pin_o,
	output int nmi_edges_o,
	output int init_seen_o
);
	logic nmi_q; // Last NMI level
	logic act_q; // Last init activity
	int nmi_cnt = 0; // Rising NMI edges seen
	int init_cnt = 0; // Init pulses seen
	// Pull-up holds the line when released
	assign ign_pin_o = ign_oe_i ? ign_n_i : 1'b1;
	// Counters have one driver each, the ports only mirror them
	assign nmi_edges_o = nmi_cnt;
	assign init_seen_o = init_cnt;
	// Only a rising NMI is a new event
	always @(posedge clk_i) begin
		if (nmi_i === 1'b1 && nmi_q === 1'b0) nmi_cnt <= nmi_cnt + 1;
		if ((init_i ^ strap_i) === 1'b1 && act_q === 1'b0) init_cnt <= init_cnt + 1;
		nmi_q <= nmi_i;
		act_q <= init_i ^ strap_i;
	end
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/100ps
// Register-driven tests of the sideband block
module tb_top
	import cpusb_pkg::*;
;
	localparam logic [11:0] FAST = {FAST_CTRL_IDX, 2'b00};
	localparam logic [11:0] CLR = {CPERR_CLR_IDX, 2'b00};
	logic clk_i, rst_i, cyc, stb, we, err_n, kbc_n, serr_n, chk_n, shut, ext, susp, strap;
	logic [11:0] adr;
	logic [3:0] sel; // Byte lanes of the request
	logic [31:0] dat, q;
	wire logic [31:0] rdat;
	wire logic ack, coproc_error_request, cpu_irq_out, ign_n, ign_oe, init, nmi, ign_pin;
	int failures = 0;
	int total_checks = 0;
	int nmi_edges, init_seen, n0;
	cpusb_top u_cpusb_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .coproc_error_in_n_i(err_n), .kbc_reset_request_n_i(kbc_n),
		.pci_serr_n_i(serr_n), .isa_channel_check_n_i(chk_n), .shutdown_cycle_i(shut),
		.ext_irq_pending_i(ext), .power_on_suspend_i(susp), .cpu_type_strap_i(strap),
		.coproc_error_request_o(coproc_error_request), .cpu_irq_out_o(cpu_irq_out), .ignore_numeric_exc_n_o(ign_n),
		.ignore_numeric_exc_n_oe_o(ign_oe), .init_o(init), .nmi_o(nmi));
	cpusb_host_model u_cpusb_host_model (.clk_i(clk_i), .strap_i(strap), .init_i(init),
		.nmi_i(nmi), .ign_n_i(ign_n), .ign_oe_i(ign_oe), .ign_pin_o(ign_pin),
		.nmi_edges_o(nmi_edges), .init_seen_o(init_seen));
	// Free-running 8 ns clock
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Classic cycle: hold until ack is sampled, then drop for a cycle
	// Waits as long as it takes; only the watchdog ends a hang
	task automatic bus(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] s = 4'h1);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dat <= d;
		@(posedge clk_i);
		while (ack !== 1'b1) begin
			@(posedge clk_i);
			n++;
		end
		// Slave answers one cycle after taking the request
		chk("ack_wait", 1, n);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rchk(string what, logic [11:0] a, logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(what, exp, q);
	endtask
	// Long enough for a whole 64-cycle pulse
	task automatic init_chk(string what, int n);
		repeat (70) @(posedge clk_i);
		chk(what, n, init_seen);
	endtask
	task automatic finish_test;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Watchdog well beyond the test length
	initial begin
		repeat (5000) @(posedge clk_i);
		failures++;
		finish_test;
	end
	initial begin
		{cyc, stb, we, shut, ext, susp, strap} = 7'h00;
		{err_n, kbc_n, serr_n, chk_n, rst_i} = 5'h1f;
		adr = 12'h000;
		sel = 4'h0;
		dat = 32'h0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rchk("rst_ctrl", RST_CTRL_ADDR, 32'h0);
		rchk("nmi_mask", NMI_MASK_ADDR, 32'h80);
		// Write without lane zero must leave the mask set
		bus(1'b1, NMI_MASK_ADDR, 32'h00, 4'he);
		rchk("sel_refused", NMI_MASK_ADDR, 32'h80);
		rchk("unmapped", 12'h004, 32'h0);
		$display("test registers done");
		bus(1'b1, FAST, 32'h01);
		init_chk("port", 1);
		bus(1'b1, RST_CTRL_ADDR, 32'h04);
		init_chk("soft", 2);
		bus(1'b1, RST_CTRL_ADDR, 32'h00);
		bus(1'b1, RST_CTRL_ADDR, 32'h06);
		init_chk("sysrst", 2);
		shut <= 1'b1;
		@(posedge clk_i);
		shut <= 1'b0;
		init_chk("shutdown", 3);
		kbc_n <= 1'b0;
		init_chk("kbc", 4);
		kbc_n <= 1'b1;
		$display("test init done");
		bus(1'b1, RST_CTRL_ADDR, 32'h01);
		bus(1'b1, CLR, 32'h0);
		chk("ign_idle", 1, ign_pin);
		err_n <= 1'b0;
		repeat (5) @(posedge clk_i);
		chk("coproc_error_request", 1, coproc_error_request);
		bus(1'b1, CLR, 32'h0);
		@(posedge clk_i);
		chk("ign_on", 0, ign_pin);
		rchk("rc_status", RST_CTRL_ADDR, 32'h61);
		err_n <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk("ign_off", 1, ign_pin);
		bus(1'b1, RST_CTRL_ADDR, 32'h00);
		err_n <= 1'b0;
		repeat (5) @(posedge clk_i);
		bus(1'b1, CLR, 32'h0);
		@(posedge clk_i);
		chk("ign_dis", 1, ign_pin);
		err_n <= 1'b1;
		$display("test ignore done");
		for (int s = 0; s < 2; s++) begin
			serr_n <= (s != 0);
			chk_n <= (s == 0);
			repeat (6) @(posedge clk_i);
			chk("nmi_masked", 0, nmi);
			bus(1'b1, NMI_MASK_ADDR, 32'h00);
			repeat (3) @(posedge clk_i);
			chk("nmi_edges", s + 1, nmi_edges);
			rchk("nmi_status", NMI_SC_ADDR, s == 0 ? 32'h80 : 32'h40);
			bus(1'b1, NMI_SC_ADDR, s == 0 ? 32'h04 : 32'h08);
			serr_n <= 1'b1;
			chk_n <= 1'b1;
			repeat (3) @(posedge clk_i);
			chk("nmi_clear", 0, nmi);
			bus(1'b1, NMI_SC_ADDR, 32'h00);
			bus(1'b1, NMI_MASK_ADDR, 32'h80);
		end
		ext <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk("cpu_irq_out", 1, cpu_irq_out);
		susp <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk("cpu_irq_out_susp", 0, cpu_irq_out);
		{susp, ext} <= 2'b00;
		$display("test nmi and interrupt done");
		rst_i <= 1'b1;
		strap <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk("init_idle", 1, init);
		rst_i <= 1'b0;
		n0 = init_seen;
		@(posedge clk_i);
		bus(1'b1, FAST, 32'h01);
		chk("init_low", 0, init);
		init_chk("strap", n0 + 1);
		$display("test strap done");
		finish_test;
	end
endmodule
